// ---- rtl/fault_word.sv ----
// Controller fault summary word with LED view and Wishbone access
// How it works
// - Network error in any remote station sets bit 1.
// - Remote configuration or transmission error sets bit 2.
// - Local expansion module status error sets bit 3.
// - Wrong or faulty local expansion module sets bit 4.
// - Faulty or unsuitable memory card sets bit 5.
// - Low backup battery sets bit 6.
// - Power failure sets bit 7; DC supply failure sets bit 14.
// - Warm start after category E with halt option sets bit 9; marker reset needed.
// - Run-time program error sets bit 10.
// - Corrupted retained data sets bit 11.
// - User program checksum mismatch sets bit 12.
// - Scan exceeding maximum cycle time sets bit 15.
// - LEDs 1-7 show bits 1-7 in Run/Ready, 9-15 in Not Ready; LED 0 dark.
// - Switch at Run or Run/M reset plus reset button clears flags.
// - Any bit 8-15 set forces Not Ready.
// - Bits 0-7 are informational and never stop operation.
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module fault_word
	import fault_word_pkg::*;
#(
	parameter int SCAN_DIV = 250
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Fault sources
	input wire logic remote_station_fault_i,
	input wire logic remote_config_fault_i,
	input wire logic local_module_status_fault_i,
	input wire logic local_module_config_fault_i,
	input wire logic memory_card_fault_i,
	input wire logic battery_low_flag_i,
	input wire logic power_fail_i,
	input wire logic warm_start_i,
	input wire logic runtime_fault_i,
	input wire logic retained_data_corrupt_i,
	input wire logic program_checksum_fault_i,
	input wire logic dc_supply_fault_i,
	input wire logic cycle_overrun_fault_i,
	// Front panel
	input wire logic [1:0] mode_switch_i,
	input wire logic reset_button_i,
	output logic [7:0] led_o,
	output logic not_ready_o,
	output logic run_o,
	output logic restart_needs_marker_clear_o,
	output logic irq_o
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] fault;
		logic [15:0] mask;
		logic [1:0] ctrl;
		plc_state_t plc;
		logic btn_q;
		logic [7:0] led;
		logic irq;
		logic ack;
		logic [31:0] rdata;
	} fw_state_t;
	fw_state_t st, next_st;
	logic tick;
	logic [15:0] set_vec;
	logic [15:0] wmask;
	logic ack_press;
	logic wr;
	logic rd;

	function automatic logic [15:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
	endfunction : lane_mask

	// ------------------------------------------------------------
	// Scan cycle clock
	// ------------------------------------------------------------
	scan_tick #(
		.DIV(SCAN_DIV)
	) u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_o(tick)
	);

	// ------------------------------------------------------------
	// Fault detection vector
	// ------------------------------------------------------------
	always_comb begin
		set_vec = 16'h0000;
		set_vec[BIT_REMOTE_STATION] = remote_station_fault_i;
		set_vec[BIT_REMOTE_CONFIG] = remote_config_fault_i;
		set_vec[BIT_LOCAL_STATUS] = local_module_status_fault_i;
		set_vec[BIT_LOCAL_CONFIG] = local_module_config_fault_i;
		set_vec[BIT_MEMORY_CARD] = memory_card_fault_i;
		set_vec[BIT_BATTERY] = battery_low_flag_i;
		set_vec[BIT_POWER] = power_fail_i;
		set_vec[BIT_DC_SUPPLY] = dc_supply_fault_i;
		// Warm start tried while halted on a category E error
		set_vec[BIT_RESTART_MARKER] = warm_start_i && st.ctrl[CTRL_HALT_AFTER_NR]
			&& (st.plc == ST_NOT_READY);
		set_vec[BIT_RUNTIME] = runtime_fault_i;
		set_vec[BIT_RETAINED] = retained_data_corrupt_i;
		set_vec[BIT_CHECKSUM] = program_checksum_fault_i;
		set_vec[BIT_CYCLE_OVERRUN] = cycle_overrun_fault_i;
		set_vec = set_vec & FAULT_IMPL_MASK;
	end

	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !st.ack;
	assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !st.ack;
	assign wmask = lane_mask(wb_sel_i);
	// Acknowledge on rising edge of button with switch in a run position
	assign ack_press = reset_button_i && !st.btn_q
		&& (mode_switch_i == SW_RUN || mode_switch_i == SW_RUN_MRESET);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [15:0] clr;
		logic marker_restart;
		clr = 16'h0000;
		marker_restart = 1'b0;
		next_st = st;
		next_st.ack = 1'b0;
		next_st.btn_q = reset_button_i;

		// Wishbone register writes
		if (wr) begin
			next_st.ack = 1'b1;
			unique case (wb_adr_i)
				ADDR_IRQ_MASK: begin
					next_st.mask = (st.mask & ~wmask) | (wb_dat_i[15:0] & wmask);
				end
				ADDR_CONTROL: begin
					if (wb_sel_i[0]) begin
						next_st.ctrl = wb_dat_i[1:0];
					end
				end
				ADDR_EVENT_STATUS: begin
					clr = wb_dat_i[15:0] & wmask;
				end
				default: begin
				end
			endcase
		end
		if (rd) begin
			next_st.ack = 1'b1;
			unique case (wb_adr_i)
				ADDR_FAULT_WORD: next_st.rdata = {16'h0000, st.fault};
				ADDR_EVENT_STATUS: next_st.rdata = {16'h0000, st.fault};
				ADDR_IRQ_MASK: next_st.rdata = {16'h0000, st.mask};
				ADDR_CONTROL: next_st.rdata = {30'h00000000, st.ctrl};
				ADDR_STATE: next_st.rdata = {30'h00000000, st.plc};
				default: next_st.rdata = 32'h00000000;
			endcase
		end

		// Front panel acknowledge clears every flag
		if (ack_press) begin
			clr = 16'hFFFF;
		end
		// Latch until cleared; a new event wins over the clear
		next_st.fault = ((st.fault & ~clr) | set_vec) & FAULT_IMPL_MASK;

		// Controller state steps once per scan cycle
		if (tick) begin
			unique case (st.plc)
				ST_READY, ST_RUN: begin
					if ((st.fault & CAT_E_MASK) != 16'h0000) begin
						next_st.plc = ST_NOT_READY;
					end else if (mode_switch_i == SW_HALT) begin
						next_st.plc = ST_READY;
					end else begin
						next_st.plc = ST_RUN;
					end
				end
				ST_NOT_READY: begin
					// Leave only when all category E errors (bits 8-15) are gone and restart allowed
					marker_restart = !st.fault[BIT_RESTART_MARKER]
						|| mode_switch_i == SW_RUN_MRESET;
					if ((st.fault & CAT_E_MASK) == 16'h0000 && marker_restart) begin
						next_st.plc = ST_READY;
					end
				end
				default: next_st.plc = ST_NOT_READY;
			endcase
		end

		// LED view of the word
		next_st.led[0] = 1'b0;
		if (st.plc == ST_NOT_READY) begin
			next_st.led[7:1] = st.fault[15:9];
		end else begin
			next_st.led[7:1] = st.fault[7:1];
		end

		next_st.irq = (st.fault & st.mask) != 16'h0000;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
			st.fault <= FAULT_RESET;
			st.mask <= MASK_RESET;
			st.ctrl <= CTRL_RESET;
			st.plc <= ST_READY;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign wb_dat_o = st.rdata;
	assign wb_ack_o = st.ack;
	assign led_o = st.led;
	assign irq_o = st.irq;
	assign not_ready_o = (st.plc == ST_NOT_READY);
	assign run_o = (st.plc == ST_RUN);
	assign restart_needs_marker_clear_o = st.fault[BIT_RESTART_MARKER];
endmodule : fault_word

// ---- include/fault_word_pkg.sv ----
// Constants for the controller fault summary word
package fault_word_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_FAULT_WORD = 8'h00;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h04;
	localparam logic [7:0] ADDR_CONTROL = 8'h08;
	localparam logic [7:0] ADDR_STATE = 8'h0C;
	localparam logic [7:0] ADDR_EVENT_STATUS = 8'h10;
	// ------------------------------------------------------------
	// Field positions of the fault word
	// ------------------------------------------------------------
	localparam int BIT_REMOTE_STATION = 1;
	localparam int BIT_REMOTE_CONFIG = 2;
	localparam int BIT_LOCAL_STATUS = 3;
	localparam int BIT_LOCAL_CONFIG = 4;
	localparam int BIT_MEMORY_CARD = 5;
	localparam int BIT_BATTERY = 6;
	localparam int BIT_POWER = 7;
	localparam int BIT_RESTART_MARKER = 9;
	localparam int BIT_RUNTIME = 10;
	localparam int BIT_RETAINED = 11;
	localparam int BIT_CHECKSUM = 12;
	localparam int BIT_WATCHDOG = 13;
	localparam int BIT_DC_SUPPLY = 14;
	localparam int BIT_CYCLE_OVERRUN = 15;
	// Bits 0, 8 and 13 never set
	localparam logic [15:0] FAULT_IMPL_MASK = 16'hDEFE;
	localparam logic [15:0] CAT_E_MASK = 16'hFF00;
	localparam logic [15:0] FAULT_RESET = 16'h0000;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	// Control register fields
	localparam int CTRL_HALT_AFTER_NR = 0;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	// ------------------------------------------------------------
	// Modes and states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SW_HALT = 2'b00,
		SW_RUN = 2'b01,
		SW_RUN_MRESET = 2'b10
	} mode_sw_t;
	typedef enum logic [1:0] {
		ST_READY = 2'b00,
		ST_RUN = 2'b01,
		ST_NOT_READY = 2'b10
	} plc_state_t;
endpackage : fault_word_pkg

// ---- rtl/scan_tick.sv ----
// Scan cycle enable divider
`timescale 1ns/1ps
module scan_tick #(
	parameter int DIV = 250
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Enable out
	output logic tick_o
);
	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} tick_state_t;
	tick_state_t st, next_st;

	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (st.cnt == 16'(DIV - 1)) begin
			next_st.cnt = 16'h0000;
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick_o = st.tick;
endmodule : scan_tick

// ---- bench/fault_word_chk.sv ----
// Assertions on the fault word ports
`timescale 1ns/1ps
module fault_word_chk #(
	parameter int SCAN_DIV = 250
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Watched ports
	input wire logic remote_station_fault_i,
	input wire logic battery_low_flag_i,
	input wire logic runtime_fault_i,
	input wire logic warm_start_i,
	input wire logic [1:0] mode_switch_i,
	input wire logic reset_button_i,
	input wire logic [7:0] led_o,
	input wire logic not_ready_o,
	input wire logic run_o,
	input wire logic restart_needs_marker_clear_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence stay_up;
		!not_ready_o ##1 !not_ready_o;
	endsequence
	sequence press_run;
		$rose(reset_button_i) && mode_switch_i != 2'h0 && !warm_start_i;
	endsequence
	AST_LED0: assert property (led_o[0] == 1'b0)
		else $error("led 0 lit");
	AST_REMOTE: assert property ((remote_station_fault_i ##0 stay_up) |=> led_o[1])
		else $error("remote flag not shown");
	AST_BATT: assert property ((battery_low_flag_i ##0 stay_up) |=> led_o[6])
		else $error("battery flag not shown");
	AST_NR_LED: assert property (restart_needs_marker_clear_o && not_ready_o |=> led_o[1])
		else $error("restart flag not shown");
	AST_RT_NR: assert property (runtime_fault_i |-> ##[1:12] not_ready_o)
		else $error("no not ready after error");
	AST_NR_RUN: assert property (not_ready_o |-> !run_o)
		else $error("run while not ready");
	AST_CLR: assert property (press_run |=> !restart_needs_marker_clear_o)
		else $error("press did not clear");
	AST_HALT: assert property ($rose(reset_button_i) && mode_switch_i == 2'h0
		&& restart_needs_marker_clear_o |=> restart_needs_marker_clear_o)
		else $error("press at halt cleared");
endmodule : fault_word_chk
bind fault_word fault_word_chk #(.SCAN_DIV(SCAN_DIV)) chk (.*);

// ---- bench/front_panel.sv ----
// Front panel model: mode switch and reset button
`timescale 1ns/1ps
module front_panel (
	// Clock
	input wire logic clk_i,
	// Operator commands
	input wire logic [1:0] mode_req_i,
	input wire logic press_req_i,
	// Panel controls
	output logic [1:0] mode_switch_o,
	output logic reset_button_o
);
	always @(posedge clk_i) begin
		mode_switch_o <= mode_req_i;
		reset_button_o <= press_req_i;
	end
endmodule : front_panel

// ---- bench/fault_word_tb_top.sv ----
// Self-checking bench for the fault word
`timescale 1ns/1ps
module fault_word_tb_top;
	import fault_word_pkg::*;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i, led_o;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic not_ready_o, run_o, restart_needs_marker_clear_o, irq_o;
	logic [1:0] mode_switch_i, mode_req;
	logic reset_button_i, press_req, warm_start_i;
	logic [11:0] src;
	wire logic remote_station_fault_i, remote_config_fault_i, local_module_status_fault_i;
	wire logic local_module_config_fault_i, memory_card_fault_i, battery_low_flag_i;
	wire logic power_fail_i, runtime_fault_i, retained_data_corrupt_i;
	wire logic program_checksum_fault_i, dc_supply_fault_i, cycle_overrun_fault_i;
	int miscompares, cmp_count;
	int pos[12] = '{1, 2, 3, 4, 5, 6, 7, 10, 11, 12, 14, 15};
	assign {cycle_overrun_fault_i, dc_supply_fault_i, program_checksum_fault_i,
		retained_data_corrupt_i, runtime_fault_i, power_fail_i, battery_low_flag_i,
		memory_card_fault_i, local_module_config_fault_i, local_module_status_fault_i,
		remote_config_fault_i, remote_station_fault_i} = src;
	fault_word #(.SCAN_DIV(4)) dut (.*);
	front_panel panel (.clk_i(clk_i), .mode_req_i(mode_req), .press_req_i(press_req),
		.mode_switch_o(mode_switch_i), .reset_button_o(reset_button_i));
	task automatic end_sim;
		if (miscompares == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, dat};
		// Ack and read data taken as sampled at the same rising edge
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && n < 20) begin
			n++;
			@(posedge clk_i);
		end
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		@(posedge clk_i);
		if (n == 20) begin
			miscompares++;
			end_sim();
		end
	endtask : wb
	task automatic pulse(input logic [11:0] s);
		@(posedge clk_i);
		src <= s;
		@(posedge clk_i);
		src <= '0;
		repeat (12) @(posedge clk_i);
	endtask : pulse
	task automatic press(input logic [1:0] m);
		@(posedge clk_i);
		mode_req <= m;
		repeat (2) @(posedge clk_i);
		press_req <= 1'b1;
		repeat (3) @(posedge clk_i);
		press_req <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask : press
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	initial begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, press_req, warm_start_i} = 6'b100000;
		{wb_adr_i, wb_dat_i, src, mode_req} = '0;
		wb_sel_i = 4'h3;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b1, ADDR_FAULT_WORD, 32'hFFFF);
		for (int a = 0; a < 9; a++) begin
			wb(1'b0, 8'(a * 4), '0);
			cmp(rd, 32'h0);
		end
		wb(1'b1, ADDR_IRQ_MASK, 32'hFFFF);
		mode_req <= SW_RUN;
		for (int i = 0; i < 12; i++) begin
			pulse(12'h1 << i);
			wb(1'b0, ADDR_FAULT_WORD, '0);
			cmp(rd, 32'h1 << pos[i]);
			wb(1'b0, ADDR_STATE, '0);
			cmp(rd, (i > 6) ? 32'h2 : 32'h1);
			@(negedge clk_i);
			cmp({irq_o, led_o}, {1'b1, 8'((32'h1 << pos[i]) >> ((i > 6) ? 8 : 0))});
			wb(1'b1, ADDR_EVENT_STATUS, 32'hFFFF);
			wb(1'b0, ADDR_EVENT_STATUS, '0);
			cmp(rd, 32'h0);
			repeat (12) @(posedge clk_i);
		end
		wb(1'b1, ADDR_IRQ_MASK, 32'h40);
		pulse(12'h040);
		@(negedge clk_i);
		cmp(irq_o, 1'b0);
		pulse(12'h020);
		@(negedge clk_i);
		cmp(irq_o, 1'b1);
		wb(1'b1, ADDR_CONTROL, 32'h1);
		pulse(12'h080);
		@(posedge clk_i);
		warm_start_i <= 1'b1;
		@(posedge clk_i);
		warm_start_i <= 1'b0;
		wb(1'b0, ADDR_FAULT_WORD, '0);
		cmp(rd, 32'h06C0);
		cmp(restart_needs_marker_clear_o, 1'b1);
		press(SW_HALT);
		wb(1'b0, ADDR_FAULT_WORD, '0);
		cmp(rd, 32'h06C0);
		press(SW_RUN_MRESET);
		wb(1'b0, ADDR_FAULT_WORD, '0);
		cmp(rd, 32'h0);
		@(negedge clk_i);
		cmp({irq_o, led_o}, 9'h000);
		end_sim();
	end
endmodule : fault_word_tb_top
